// >>> verilog/flag_and_load_decoder.sv
// Purpose: Executes flag set/clear, register move and data load operations
//          of an 8-bit core, with an APB window on its state.
// Assumes: Single clock core_clk_i (20 MHz); synchronous active-low reset;
//          data memory returns the byte of mem_addr_o in the same cycle.
// Notes:   Loads take two cycles, every other operation one.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flag_load_map.svh"

module flag_and_load_decoder #(
   parameter int ADDR_W = 16
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Instruction port.
   input wire logic instr_valid_i,
   output logic instr_ready_o,
   input wire flag_load_pkg::op_type instr_op_i,
   input wire logic [4:0] instr_rd_i,
   input wire logic [4:0] instr_rr_i,
   input wire flag_load_pkg::ptr_type instr_ptr_i,
   input wire logic [7:0] instr_imm_i,
   output logic retire_o,
   // Data memory read port.
   output logic mem_rd_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   input wire logic [7:0] mem_rdata_i,
   // Status register view.
   output logic [7:0] status_register_o,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`FL_PADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);

   // ==========================================================
   // Elaboration check
   if (ADDR_W != `FL_PTR_W) begin : g_bad_width
      $error("ADDR_W must equal the pointer pair width");
   end

   // ==========================================================
   // Decode helpers

   // Returns {valid, value, bit position} for a flag operation.
   function automatic logic [4:0] flag_decode(
      input flag_load_pkg::op_type op
   );
      logic [4:0] res;
      res = 5'h00;
      unique case (op)
         flag_load_pkg::set_zero_op: res = {2'b11, `FL_STATUS_REGISTER_Z};
         flag_load_pkg::clear_zero_op: res = {2'b10, `FL_STATUS_REGISTER_Z};
         flag_load_pkg::set_int_enable_op: res = {2'b11, `FL_STATUS_REGISTER_I};
         flag_load_pkg::clear_int_enable_op: res = {2'b10, `FL_STATUS_REGISTER_I};
         flag_load_pkg::set_signed_test_op: res = {2'b11, `FL_STATUS_REGISTER_S};
         flag_load_pkg::clear_signed_test_op: res = {2'b10, `FL_STATUS_REGISTER_S};
         flag_load_pkg::set_overflow_op: res = {2'b11, `FL_STATUS_REGISTER_V};
         flag_load_pkg::clear_overflow_op: res = {2'b10, `FL_STATUS_REGISTER_V};
         flag_load_pkg::set_bit_copy_op: res = {2'b11, `FL_STATUS_REGISTER_T};
         flag_load_pkg::clear_bit_copy_op: res = {2'b10, `FL_STATUS_REGISTER_T};
         flag_load_pkg::set_half_carry_op: res = {2'b11, `FL_STATUS_REGISTER_H};
         flag_load_pkg::clear_half_carry_op: res = {2'b10, `FL_STATUS_REGISTER_H};
         default: res = 5'h00;
      endcase
      return res;
   endfunction

   // True for the four data memory load flavours.
   function automatic logic is_load(input flag_load_pkg::op_type op);
      return (op == flag_load_pkg::load_indirect_op) ||
         (op == flag_load_pkg::load_post_inc_op) ||
         (op == flag_load_pkg::load_pre_dec_op) ||
         (op == flag_load_pkg::load_with_offset_op);
   endfunction

   // Low register index of a pointer pair.
   function automatic logic [4:0] ptr_base(
      input flag_load_pkg::ptr_type sel
   );
      logic [4:0] idx;
      idx = `FL_PTR_Z_LO;
      unique case (sel)
         flag_load_pkg::ptr_x: idx = `FL_PTR_X_LO;
         flag_load_pkg::ptr_y: idx = `FL_PTR_Y_LO;
         default: idx = `FL_PTR_Z_LO;
      endcase
      return idx;
   endfunction

   // True for an APB address that holds a register.
   function automatic logic is_mapped(input logic [`FL_PADDR_W-1:0] a);
      return (a == `FL_ADDR_STATUS) || (a == `FL_ADDR_CORE) ||
         (a == `FL_ADDR_SEL) || (a == `FL_ADDR_DATA);
   endfunction

   // ==========================================================
   // State and pointer path
   flag_load_pkg::core_state_type r_reg;
   flag_load_pkg::core_state_type r_next;
   logic [4:0] ptr_lo;
   logic [`FL_PTR_W-1:0] ptr_val;
   logic [`FL_PTR_W-1:0] ptr_addr;
   logic [`FL_PTR_W-1:0] ptr_after;
   logic ptr_changes;
   logic [4:0] flag_cmd;

   // Current value of the selected pointer pair.
   assign ptr_lo = ptr_base(instr_ptr_i);
   assign ptr_val = {r_reg.gpr[ptr_lo | 5'h01], r_reg.gpr[ptr_lo]};
   assign flag_cmd = flag_decode(instr_op_i);

   pointer_unit u_ptr (
      .ptr_i(ptr_val),
      .op_i(instr_op_i),
      .offset_i(instr_imm_i),
      .addr_o(ptr_addr),
      .ptr_next_o(ptr_after),
      .ptr_write_o(ptr_changes)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      r_next = r_reg;
      r_next.retire = 1'b0;
      r_next.mem_rd = 1'b0;

      // APB setup phase latches read data and the error answer.
      if (psel_i && !penable_i) begin
         r_next.pslverr = !is_mapped(paddr_i);
         r_next.prdata = 32'h0000_0000;
         if (paddr_i == `FL_ADDR_STATUS) begin
            r_next.prdata[7:0] = r_reg.status_register;
         end else if (paddr_i == `FL_ADDR_CORE) begin
            r_next.prdata[7:0] = {r_reg.last_op, r_reg.mem_rd,
               r_reg.state == flag_load_pkg::st_load,
               r_reg.state == flag_load_pkg::st_idle};
         end else if (paddr_i == `FL_ADDR_SEL) begin
            r_next.prdata[4:0] = r_reg.reg_sel;
         end else if (paddr_i == `FL_ADDR_DATA) begin
            r_next.prdata[7:0] = r_reg.gpr[r_reg.reg_sel];
         end
      end

      // APB access phase applies writes; the core below overrides them.
      if (psel_i && penable_i && pwrite_i) begin
         if (paddr_i == `FL_ADDR_STATUS) begin
            r_next.status_register = pwdata_i[7:0];
         end else if (paddr_i == `FL_ADDR_SEL) begin
            r_next.reg_sel = pwdata_i[4:0];
         end else if (paddr_i == `FL_ADDR_DATA) begin
            r_next.gpr[r_reg.reg_sel] = pwdata_i[7:0];
         end
      end

      // Instruction execution.
      unique case (r_reg.state)
         flag_load_pkg::st_idle: begin
            if (instr_valid_i) begin
               r_next.last_op = instr_op_i;
               if (is_load(instr_op_i)) begin
                  // First load cycle registers the address; the read runs in the second.
                  r_next.state = flag_load_pkg::st_load;
                  r_next.mem_addr = ptr_addr;
                  r_next.mem_rd = 1'b1;
                  r_next.dest = instr_rd_i;
                  r_next.ptr_idx = ptr_lo;
                  r_next.ptr_wr = ptr_changes;
                  r_next.ptr_new = ptr_after;
               end else begin
                  r_next.retire = 1'b1;
                  // Single flag forced, all others kept.
                  if (flag_cmd[4]) begin
                     r_next.status_register[flag_cmd[2:0]] = flag_cmd[3];
                  end
                  if (instr_op_i == flag_load_pkg::register_copy_op) begin
                     r_next.gpr[instr_rd_i] = r_reg.gpr[instr_rr_i];
                  end
                  if (instr_op_i == flag_load_pkg::register_pair_copy_op)
                  begin
                     r_next.gpr[instr_rd_i & 5'h1E] =
                        r_reg.gpr[instr_rr_i & 5'h1E];
                     r_next.gpr[instr_rd_i | 5'h01] =
                        r_reg.gpr[instr_rr_i | 5'h01];
                  end
                  if (instr_op_i == flag_load_pkg::load_constant_op) begin
                     r_next.gpr[instr_rd_i] = instr_imm_i;
                  end
               end
            end
         end
         flag_load_pkg::st_load: begin
            // Second cycle: pointer update, then data, flags untouched.
            if (r_reg.ptr_wr) begin
               r_next.gpr[r_reg.ptr_idx] = r_reg.ptr_new[7:0];
               r_next.gpr[r_reg.ptr_idx | 5'h01] = r_reg.ptr_new[15:8];
            end
            r_next.gpr[r_reg.dest] = mem_rdata_i;
            r_next.retire = 1'b1;
            r_next.state = flag_load_pkg::st_idle;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         r_reg <= '0;
         r_reg.state <= flag_load_pkg::st_idle;
         r_reg.status_register <= `FL_STATUS_REGISTER_RESET;
         r_reg.gpr <= {`FL_GPR_COUNT{`FL_GPR_RESET}};
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Outputs
   assign instr_ready_o = (r_reg.state == flag_load_pkg::st_idle);
   assign retire_o = r_reg.retire;
   assign mem_rd_o = r_reg.mem_rd;
   assign mem_addr_o = r_reg.mem_addr;
   assign status_register_o = r_reg.status_register;
   assign prdata_o = r_reg.prdata;
   assign pready_o = 1'b1; // Every access completes without wait states.
   assign pslverr_o = psel_i && penable_i && r_reg.pslverr;

endmodule
`default_nettype wire

// >>> verilog/flag_load_map.svh
// Purpose: Named offsets, field positions and reset values of the
//          flag and load execution slice.
// Assumes: Included by its bare name from the package and the modules.
// Notes:   Definitions only.
`ifndef FLAG_LOAD_MAP_SVH
`define FLAG_LOAD_MAP_SVH

// ==========================================================
// Register bus map
`define FL_PADDR_W 8
`define FL_ADDR_STATUS 8'h00
`define FL_ADDR_CORE 8'h04
`define FL_ADDR_SEL 8'h08
`define FL_ADDR_DATA 8'h0C

// ==========================================================
// Status register bit positions and reset value
`define FL_STATUS_REGISTER_C 3'h0
`define FL_STATUS_REGISTER_Z 3'h1
`define FL_STATUS_REGISTER_N 3'h2
`define FL_STATUS_REGISTER_V 3'h3
`define FL_STATUS_REGISTER_S 3'h4
`define FL_STATUS_REGISTER_H 3'h5
`define FL_STATUS_REGISTER_T 3'h6
`define FL_STATUS_REGISTER_I 3'h7
`define FL_STATUS_REGISTER_RESET 8'h00

// ==========================================================
// Register file and pointer pairs
`define FL_GPR_COUNT 32
`define FL_GPR_RESET 8'h00
`define FL_PTR_W 16
`define FL_PTR_X_LO 5'h1A
`define FL_PTR_Y_LO 5'h1C
`define FL_PTR_Z_LO 5'h1E
`define FL_DISP_W 6
`define FL_PTR_STEP 16'h0001

`endif

// >>> verilog/flag_load_pkg.sv
// Purpose: Types shared by the flag and load execution slice.
// Assumes: flag_load_map.svh supplies the register count and pointer width.
// Notes:   Nothing here is imported; users write the package name.
`include "flag_load_map.svh"

package flag_load_pkg;

   // ==========================================================
   // Operations accepted on the instruction port
   typedef enum logic [4:0] {
      nop_op = 5'h00,
      set_zero_op = 5'h01,
      clear_zero_op = 5'h02,
      set_int_enable_op = 5'h03,
      clear_int_enable_op = 5'h04,
      set_signed_test_op = 5'h05,
      clear_signed_test_op = 5'h06,
      set_overflow_op = 5'h07,
      clear_overflow_op = 5'h08,
      set_bit_copy_op = 5'h09,
      clear_bit_copy_op = 5'h0A,
      set_half_carry_op = 5'h0B,
      clear_half_carry_op = 5'h0C,
      register_copy_op = 5'h0D,
      register_pair_copy_op = 5'h0E,
      load_constant_op = 5'h0F,
      load_indirect_op = 5'h10,
      load_post_inc_op = 5'h11,
      load_pre_dec_op = 5'h12,
      load_with_offset_op = 5'h13
   } op_type;

   // Pointer pair selection.
   typedef enum logic [1:0] {
      ptr_x = 2'h0,
      ptr_y = 2'h1,
      ptr_z = 2'h2
   } ptr_type;

   // Execution states.
   typedef enum logic {
      st_idle = 1'b0,
      st_load = 1'b1
   } state_type;

   // All state of the execution slice.
   typedef struct packed {
      state_type state;
      logic [`FL_GPR_COUNT-1:0][7:0] gpr;
      logic [7:0] status_register;
      logic [`FL_PTR_W-1:0] mem_addr;
      logic mem_rd;
      logic [4:0] dest;
      logic [4:0] ptr_idx;
      logic ptr_wr;
      logic [`FL_PTR_W-1:0] ptr_new;
      logic retire;
      logic [4:0] last_op;
      logic [4:0] reg_sel;
      logic [31:0] prdata;
      logic pslverr;
   } core_state_type;

endpackage

// >>> verilog/pointer_unit.sv
// Purpose: Address and pointer update for indirect data loads.
// Assumes: Pointer pairs are 16 bits wide; displacement is 6 bits.
// Notes:   Purely combinational; the caller registers its results.
`timescale 1ns/1ps
`default_nettype none
`include "flag_load_map.svh"

module pointer_unit (
   // Pointer and operation.
   input wire logic [`FL_PTR_W-1:0] ptr_i,
   input wire flag_load_pkg::op_type op_i,
   input wire logic [7:0] offset_i,
   // Results.
   output logic [`FL_PTR_W-1:0] addr_o,
   output logic [`FL_PTR_W-1:0] ptr_next_o,
   output logic ptr_write_o
);

   // ==========================================================
   // Access address and new pointer value per load flavour
   always_comb begin
      addr_o = ptr_i;
      ptr_next_o = ptr_i;
      ptr_write_o = 1'b0;
      unique case (op_i)
         flag_load_pkg::load_post_inc_op: begin
            ptr_next_o = ptr_i + `FL_PTR_STEP; // Read old, then step.
            ptr_write_o = 1'b1;
         end
         flag_load_pkg::load_pre_dec_op: begin
            ptr_next_o = ptr_i - `FL_PTR_STEP; // Step first, then read.
            addr_o = ptr_i - `FL_PTR_STEP;
            ptr_write_o = 1'b1;
         end
         flag_load_pkg::load_with_offset_op: begin
            // The pointer itself stays untouched.
            addr_o = ptr_i + `FL_PTR_W'(offset_i[`FL_DISP_W-1:0]);
         end
         default: begin
            addr_o = ptr_i; // Plain indirect read.
         end
      endcase
   end

endmodule
`default_nettype wire

// >>> sim/flag_load_checker.sv
// Purpose: Assertions on the flag and load execution slice.
// Assumes: Single clock; no APB status write beside an operation.
// Notes: Bound to the slice at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module flag_load_checker (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Instruction side.
   input wire logic instr_valid_i,
   input wire logic instr_ready_o,
   input wire flag_load_pkg::op_type instr_op_i,
   input wire logic retire_o,
   input wire logic mem_rd_o,
   input wire logic [7:0] status_register_o,
   // APB side.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [7:0] paddr_i,
   input wire logic pready_o,
   input wire logic pslverr_o
);
   // ==========================================
   // Helper logic
   // An operation is taken when valid meets ready; loads have high codes.
   wire logic tk = instr_valid_i && instr_ready_o;
   wire logic ld = instr_op_i >= flag_load_pkg::load_indirect_op;
   logic s_q;
   logic [7:0] st_q;
   // Keeps the set sense and the flags of the taking cycle.
   always_ff @(posedge core_clk_i) begin
      s_q <= instr_op_i[0];
      st_q <= status_register_o;
   end
   // Flags expected after setting or clearing the bits of m.
   function automatic logic [7:0] upd(input logic [7:0] m);
      return s_q ? (st_q | m) : (st_q & ~m);
   endfunction
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // Assertions
   a_ovf_flag: assert property (
      tk && instr_op_i inside {5'h07, 5'h08} |=> retire_o &&
      status_register_o == upd(8'h08)) else $error("overflow op wrong");
   a_half_flag: assert property (
      tk && instr_op_i inside {5'h0B, 5'h0C} |=> retire_o &&
      status_register_o == upd(8'h20)) else $error("half op wrong");
   a_signed_flag: assert property (
      tk && instr_op_i inside {5'h05, 5'h06} |=> retire_o &&
      status_register_o == upd(8'h10)) else $error("signed op wrong");
   a_zero_flag: assert property (
      tk && instr_op_i inside {5'h01, 5'h02} |=> retire_o &&
      status_register_o == upd(8'h02)) else $error("zero op wrong");
   a_load_timing: assert property (
      tk && ld |=> !instr_ready_o && mem_rd_o && !retire_o ##1
      retire_o && instr_ready_o && !mem_rd_o) else $error("load timing");
   a_load_flags: assert property (
      tk && ld |=> $stable(status_register_o)[*2])
      else $error("load changed flags");
   a_quick_retire: assert property (
      tk && !ld |=> retire_o && !mem_rd_o) else $error("slow retire");
   a_bus_error: assert property (
      psel_i && penable_i |-> pready_o && pslverr_o ==
      !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C}))
      else $error("bus error flag wrong");
endmodule
bind flag_and_load_decoder flag_load_checker i_flag_load_checker (
   .core_clk_i, .rst_n_i, .instr_valid_i, .instr_ready_o, .instr_op_i,
   .retire_o, .mem_rd_o, .status_register_o, .psel_i, .penable_i,
   .paddr_i, .pready_o, .pslverr_o);
`default_nettype wire

// >>> sim/data_mem_model.sv
// Purpose: Data memory answering the slice's load reads.
// Assumes: The byte stored at an address is a fixed mix of its halves.
// Notes: Outside a read the port shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
   // Clock and read port.
   input wire logic core_clk_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] mem_addr_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] last_reg = 8'h00;
   wire logic [7:0] byte_w = mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3C;
   // Remembers the last byte so a stale read never looks right.
   always_ff @(posedge core_clk_i) begin
      if (mem_rd_i) begin
         last_reg <= byte_w;
      end
   end
   assign mem_rdata_o = mem_rd_i ? byte_w : ~last_reg;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench of the flag and load slice.
// Assumes: APB answers with no fixed wait; the bench polls pready.
// Notes: Pointer and target registers are reached over APB.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ==========================================
   // Signals
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   flag_load_pkg::op_type instr_op_i = flag_load_pkg::nop_op;
   logic [4:0] instr_rd_i = 5'h00;
   logic [4:0] instr_rr_i = 5'h00;
   flag_load_pkg::ptr_type instr_ptr_i = flag_load_pkg::ptr_x;
   logic [7:0] instr_imm_i = 8'h00;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic instr_ready_o, retire_o, mem_rd_o, pready_o, pslverr_o;
   logic [15:0] mem_addr_o;
   logic [7:0] mem_rdata_i, status_register_o;
   logic [31:0] prdata_o;
   int err_total = 0;
   int total_checks = 0;
   // Clock of 50 ns.
   always #25 core_clk_i = ~core_clk_i;
   // Slice and its memory.
   flag_and_load_decoder i_flag_and_load_decoder (.core_clk_i, .rst_n_i,
      .instr_valid_i, .instr_ready_o, .instr_op_i, .instr_rd_i,
      .instr_rr_i, .instr_ptr_i, .instr_imm_i, .retire_o, .mem_rd_o,
      .mem_addr_o, .mem_rdata_i, .status_register_o, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
   data_mem_model i_data_mem_model (.core_clk_i, .mem_rd_i(mem_rd_o),
      .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));
   // ==========================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One APB transfer, held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (pready_o !== 1'b1) begin
         err_total++;
         close_out();
      end
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h00_0000, d}, q, e);
   endtask
   task automatic rreg(input logic [4:0] i, output logic [31:0] q);
      logic e;
      wr(8'h08, {3'h0, i});
      apb(1'b0, 8'h0C, 32'h0000_0000, q, e);
   endtask
   // One operation; a load also has its read port and retire checked.
   task automatic run(input flag_load_pkg::op_type op, input logic [1:0] p,
      input logic ld, input logic [15:0] a);
      @(posedge core_clk_i);
      instr_valid_i <= 1'b1;
      instr_op_i <= op;
      instr_rd_i <= 5'h05;
      instr_ptr_i <= flag_load_pkg::ptr_type'(p);
      instr_imm_i <= 8'h2D;
      @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      @(posedge core_clk_i);
      check(retire_o, !ld);
      if (ld) begin
         check({mem_rd_o, instr_ready_o, mem_addr_o}, {2'b10, a});
         @(posedge core_clk_i);
         check(retire_o, 1'b1);
      end
   endtask
   // ==========================================
   // Scenarios
   // Reset flags, then a read of an unmapped place.
   task automatic test_apb;
      logic [31:0] q;
      logic e;
      apb(1'b0, 8'h00, 32'h0000_0000, q, e);
      check(q, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0000_0000, q, e);
      check({e, q}, {1'b1, 32'h0000_0000});
      // Core view after reset: idle, nothing loaded yet.
      apb(1'b0, 8'h04, 32'h0000_0000, q, e);
      check({e, q}, {1'b0, 32'h0000_0001});
      $display("test_apb done");
   endtask
   // Constant load, single copy and pair copy into r5 and r4.
   task automatic test_moves;
      logic [31:0] q;
      run(flag_load_pkg::load_constant_op, 2'h0, 1'b0, 16'h0000);
      rreg(5'h05, q);
      check(q, 32'h0000_002D);
      wr(8'h08, 8'h06);
      wr(8'h0C, 8'h3C);
      wr(8'h08, 8'h07);
      wr(8'h0C, 8'hA5);
      @(posedge core_clk_i);
      instr_rr_i <= 5'h07;
      run(flag_load_pkg::register_copy_op, 2'h0, 1'b0, 16'h0000);
      rreg(5'h05, q);
      check(q, 32'h0000_00A5);
      wr(8'h0C, 8'h00);
      run(flag_load_pkg::register_pair_copy_op, 2'h0, 1'b0, 16'h0000);
      rreg(5'h04, q);
      check(q, 32'h0000_003C);
      rreg(5'h05, q);
      check(q, 32'h0000_00A5);
      $display("test_moves done");
   endtask
   // Every set against all-clear flags and every clear against all-set flags.
   task automatic test_flags;
      logic [7:0] m [12] = '{8'h02, 8'h02, 8'h80, 8'h80, 8'h10, 8'h10,
         8'h08, 8'h08, 8'h40, 8'h40, 8'h20, 8'h20};
      for (int i = 1; i <= 12; i++) begin
         wr(8'h00, i[0] ? 8'h00 : 8'hFF);
         run(flag_load_pkg::op_type'(i[4:0]), 2'h0, 1'b0, 16'h0000);
         check(status_register_o, i[0] ? m[i-1] : m[i-1] ^ 8'hFF);
      end
      $display("test_flags done");
   endtask
   // The four loads on pointer 0x0100; pre-decrement crosses a byte.
   task automatic test_loads;
      logic [15:0] a, np;
      logic [4:0] lo;
      logic [31:0] q;
      for (int k = 0; k < 4; k++) begin
         lo = 5'h1A + 5'(2 * (k % 3));
         a = (k == 2) ? 16'h00FF : (k == 3) ? 16'h012D : 16'h0100;
         np = (k == 1) ? 16'h0101 : (k == 2) ? 16'h00FF : 16'h0100;
         wr(8'h08, {3'h0, lo});
         wr(8'h0C, 8'h00);
         wr(8'h08, {3'h0, lo + 5'h01});
         wr(8'h0C, 8'h01);
         wr(8'h00, 8'h5A);
         run(flag_load_pkg::op_type'(5'h10 + k[4:0]), 2'(k % 3), 1'b1, a);
         check(status_register_o, 8'h5A);
         rreg(5'h05, q);
         check(q, a[7:0] ^ a[15:8] ^ 8'h3C);
         rreg(lo, q);
         check(q, np[7:0]);
         rreg(lo + 5'h01, q);
         check(q, np[15:8]);
      end
      $display("test_loads done");
   endtask
   // Reset for four cycles, then the scenarios.
   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      test_apb();
      test_flags();
      test_moves();
      test_loads();
      close_out();
   end
endmodule
`default_nettype wire
